// ### src/dpc_pkg.sv
// ==================================================================
// Shared constants and types for the dual pulse counter block
package dpc_pkg;

  // ================================================================
  // Register indices (byte address is four times the index)
  localparam logic [7:0] RTC_CONTROL_IDX = 8'h20;
  localparam logic [7:0] PULSE_COUNTER_CONTROL_IDX = 8'h40;
  localparam logic [7:0] COUNT_ONE_LOW_IDX = 8'h41;
  localparam logic [7:0] COUNT_ONE_HIGH_IDX = 8'h42;
  localparam logic [7:0] COUNT_TWO_LOW_IDX = 8'h43;
  localparam logic [7:0] COUNT_TWO_HIGH_IDX = 8'h44;

  // ================================================================
  // Field positions in the pulse counter control register
  localparam int CTRL_ONE_ENABLE_BIT = 7;
  localparam int CTRL_ONE_IRQ_ENABLE_BIT = 6;
  localparam int CTRL_ONE_FLAG_BIT = 4;
  localparam int CTRL_TWO_ENABLE_BIT = 3;
  localparam int CTRL_TWO_IRQ_ENABLE_BIT = 2;
  localparam int CTRL_TWO_FLAG_BIT = 0;
  // Field positions in the clock control register
  localparam int RTC_FLAG_BIT = 1;
  localparam int RTC_IRQ_ENABLE_BIT = 0;

  // ================================================================
  // Reset values and counter limits
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_ALL_ONES = 16'hFFFF;

  // ================================================================
  // Timing: extra pulse width needed for counting across a read
  localparam int CLK_PERIOD_NS = 5;
  localparam int READ_PULSE_MARGIN_NS = 500;
  localparam int READ_PULSE_MARGIN_CYC =
    (READ_PULSE_MARGIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ================================================================
  // Per-counter control bits
  typedef struct packed {
    logic enable;
    logic irq_enable;
    logic flag;
  } dpc_cnt_ctrl_s;

endpackage

// ### src/dpc_top.sv
`timescale 1ns/100ps
module dpc_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pulse pins
  input wire logic pulse_input_one,
  input wire logic pulse_input_two,
  // Interrupt path
  input wire logic external_irq_pin_n,
  input wire logic rtc_overflow,
  input wire logic irq_in_service,
  output logic ext_irq_req,
  output logic deriv_irq_grant
);

  // Declarations
  dpc_pkg::dpc_cnt_ctrl_s ctrl [2];
  logic [15:0] count [2];
  logic [2:0] pin_sync [2];
  logic pin_level [2];
  logic fall [2];
  logic origin_zero [2];
  logic skip_flag [2];
  logic rtc_tick_flag;
  logic rtc_tick_irq_enable;
  logic [2:0] ext_sync;
  logic ext_level_n;
  logic [7:0] idx;
  logic addr_ok;
  logic bus_wr;
  logic ctrl_wr;
  logic rtc_wr;
  logic lo_wr [2];
  logic hi_wr [2];
  logic [7:0] next_rdata;
  logic deriv_req;

  // Packs one counter's control bits into a nibble
  function automatic logic [3:0] ctrl_nibble(input dpc_pkg::dpc_cnt_ctrl_s c);
    ctrl_nibble = {c.enable, c.irq_enable, 1'b0, c.flag};
  endfunction

  // Checks whether an address index is one of the mapped registers
  function automatic logic idx_mapped(input logic [7:0] i);
    idx_mapped = (i == dpc_pkg::RTC_CONTROL_IDX) ||
      (i >= dpc_pkg::PULSE_COUNTER_CONTROL_IDX && i <= dpc_pkg::COUNT_TWO_HIGH_IDX);
  endfunction

  // ================================================================
  // Address decode
  assign idx = paddr[9:2];
  assign addr_ok = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0) && idx_mapped(idx);
  assign bus_wr = psel && penable && pready && pwrite && addr_ok;
  assign ctrl_wr = bus_wr && (idx == dpc_pkg::PULSE_COUNTER_CONTROL_IDX);
  assign rtc_wr = bus_wr && (idx == dpc_pkg::RTC_CONTROL_IDX);
  assign lo_wr[0] = bus_wr && (idx == dpc_pkg::COUNT_ONE_LOW_IDX);
  assign hi_wr[0] = bus_wr && (idx == dpc_pkg::COUNT_ONE_HIGH_IDX);
  assign lo_wr[1] = bus_wr && (idx == dpc_pkg::COUNT_TWO_LOW_IDX);
  assign hi_wr[1] = bus_wr && (idx == dpc_pkg::COUNT_TWO_HIGH_IDX);

  // ================================================================
  // APB handshake: one wait-free access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable && !pready;
      pslverr <= psel && !penable && !pready && !addr_ok;
    end
  end

  // Read data selection
  // byte-wise readback
  always_comb
  begin
    next_rdata = 8'h00;
    case (idx)
      dpc_pkg::RTC_CONTROL_IDX:
        next_rdata = {6'h00, rtc_tick_flag, rtc_tick_irq_enable};
      dpc_pkg::PULSE_COUNTER_CONTROL_IDX:
        next_rdata = {ctrl_nibble(ctrl[0]), ctrl_nibble(ctrl[1])};
      dpc_pkg::COUNT_ONE_LOW_IDX: next_rdata = count[0][7:0];
      dpc_pkg::COUNT_ONE_HIGH_IDX: next_rdata = count[0][15:8];
      dpc_pkg::COUNT_TWO_LOW_IDX: next_rdata = count[1][7:0];
      dpc_pkg::COUNT_TWO_HIGH_IDX: next_rdata = count[1][15:8];
      default: next_rdata = 8'h00;
    endcase
  end

  // Read data register, loaded in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (psel && !penable)
      prdata <= {24'h000000, (!pwrite && addr_ok) ? next_rdata : 8'h00};
  end

  // ================================================================
  // Pulse pin synchronisers with agreement filter
  // three-stage crossing of pulse pins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_sync[0] <= 3'h0;
      pin_sync[1] <= 3'h0;
      pin_level[0] <= 1'b0;
      pin_level[1] <= 1'b0;
    end
    else
    begin
      pin_sync[0] <= {pin_sync[0][1:0], pulse_input_one};
      pin_sync[1] <= {pin_sync[1][1:0], pulse_input_two};
      for (int i = 0; i < 2; i++)
        if (pin_sync[i][1] == pin_sync[i][2])
          pin_level[i] <= pin_sync[i][2];
    end
  end

  // high-to-low detect on the agreed level
  always_comb
    for (int i = 0; i < 2; i++)
      fall[i] = pin_level[i] && !pin_sync[i][1] && !pin_sync[i][2];

  // ================================================================
  // Counters
  // two independent counters, no low-power gating
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < 2; i++)
      begin
        // counters cleared, zero reached by reset
        count[i] <= dpc_pkg::COUNT_RESET;
        origin_zero[i] <= 1'b1;
        skip_flag[i] <= 1'b0;
      end
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (lo_wr[i] || hi_wr[i])
        begin
          // a pulse during a write is dropped
          if (lo_wr[i])
            count[i][7:0] <= pwdata[7:0];
          else
            count[i][15:8] <= pwdata[7:0];
          // arm suppression when all ones is loaded while origin_zero is set (no count since reset or the last wrap)
          skip_flag[i] <= origin_zero[i] &&
            ((lo_wr[i] ? {count[i][15:8], pwdata[7:0]} : {pwdata[7:0], count[i][7:0]})
              == dpc_pkg::COUNT_ALL_ONES);
        end
        // count only while enabled, else hold
        else if (ctrl[i].enable && fall[i])
        begin
          count[i] <= count[i] + 16'h0001;
          origin_zero[i] <= (count[i] == dpc_pkg::COUNT_ALL_ONES);
          skip_flag[i] <= 1'b0;
        end
      end
    end
  end

  // ================================================================
  // Pulse counter control register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl[0] <= '0;
      ctrl[1] <= '0;
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (ctrl_wr)
        begin
          ctrl[i].enable <= pwdata[dpc_pkg::CTRL_ONE_ENABLE_BIT - 4 * i];
          ctrl[i].irq_enable <= pwdata[dpc_pkg::CTRL_ONE_IRQ_ENABLE_BIT - 4 * i];
        end
        if (ctrl[i].enable && fall[i] && !lo_wr[i] && !hi_wr[i] &&
            ctrl[i].irq_enable && !skip_flag[i] &&
            count[i] == dpc_pkg::COUNT_ALL_ONES)
          ctrl[i].flag <= 1'b1;
        // software may set or clear the flag
        else if (ctrl_wr)
          ctrl[i].flag <= pwdata[dpc_pkg::CTRL_ONE_FLAG_BIT - 4 * i];
      end
    end
  end

  // ================================================================
  // Clock flag and its enable
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rtc_tick_flag <= 1'b0;
      rtc_tick_irq_enable <= 1'b0;
    end
    else
    begin
      if (rtc_wr)
        rtc_tick_irq_enable <= pwdata[dpc_pkg::RTC_IRQ_ENABLE_BIT];
      if (rtc_overflow)
        rtc_tick_flag <= 1'b1;
      else if (rtc_wr)
        rtc_tick_flag <= pwdata[dpc_pkg::RTC_FLAG_BIT];
    end
  end

  // ================================================================
  // Interrupt path
  // enabled flags as extra sources
  assign deriv_req = (ctrl[0].flag && ctrl[0].irq_enable) ||
    (ctrl[1].flag && ctrl[1].irq_enable) || (rtc_tick_flag && rtc_tick_irq_enable);

  // External pin crossing, active low
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ext_sync <= 3'h7;
      ext_level_n <= 1'b1;
    end
    else
    begin
      ext_sync <= {ext_sync[1:0], external_irq_pin_n};
      if (ext_sync[1] == ext_sync[2])
        ext_level_n <= ext_sync[2];
    end
  end

  // Registered interrupt outputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ext_irq_req <= 1'b0;
      deriv_irq_grant <= 1'b0;
    end
    else
    begin
      // flags ORed with the pin request
      ext_irq_req <= !ext_level_n || deriv_req;
      // serviced only when idle and pin quiet
      deriv_irq_grant <= deriv_req && !irq_in_service && ext_level_n;
    end
  end

  // ================================================================
  // Checks
  reset_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    !$past(presetn) |-> (count[0] == 16'h0000 && count[1] == 16'h0000 && ctrl[0] == '0))
    else $error("counters or control not cleared after reset");
  count_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!ctrl[0].enable && !lo_wr[0] && !hi_wr[0]) |=> $stable(count[0]))
    else $error("disabled counter changed");
  count_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl[1].enable && fall[1] && !lo_wr[1] && !hi_wr[1])
      |=> count[1] == $past(count[1]) + 16'h0001)
    else $error("counter did not step by one");
  wrap_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl[0].enable && ctrl[0].irq_enable && fall[0] && !skip_flag[0] &&
      !lo_wr[0] && !hi_wr[0] && count[0] == 16'hFFFF) |=> ctrl[0].flag && count[0] == 16'h0000)
    else $error("wrap did not set flag");
  flag_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl[1].flag && !ctrl_wr) |=> ctrl[1].flag)
    else $error("flag cleared without a write");
  skip_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    (skip_flag[0] && ctrl[0].enable && fall[0] && !ctrl[0].flag && !ctrl_wr &&
      !lo_wr[0] && !hi_wr[0]) |=> !ctrl[0].flag)
    else $error("loaded all ones still set the flag");
  irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ext_level_n && !ctrl[0].irq_enable && !ctrl[1].irq_enable && !rtc_tick_irq_enable)
      |=> !ext_irq_req)
    else $error("request raised with all enables off");
  grant_block_a: assert property (@(posedge pclk) disable iff (!presetn)
    (irq_in_service || !ext_level_n) |=> !deriv_irq_grant)
    else $error("grant while busy or pin pending");
  rtc_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    rtc_overflow |=> rtc_tick_flag)
    else $error("clock overflow did not set flag");
  ctrl_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && idx == 8'h40 && addr_ok) |=> prdata[5] == 1'b0 &&
      prdata[1] == 1'b0 && prdata[7] == $past(ctrl[0].enable))
    else $error("control readback layout wrong");
  apb_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pready) |=> pready ##1 !pready)
    else $error("access phase not one cycle");
endmodule

// ### verification/dpc_pulse_src.sv
`timescale 1ns/100ps
// ==================================================================
// Pulse sources driving both counter pins
module dpc_pulse_src #(
  parameter int HALF_CYC = 110
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Requests, one per pin
  input wire logic [1:0] start,
  input wire logic [1:0][15:0] n_pulses,
  // Pins and status
  output logic [1:0] pulse,
  output logic [1:0] busy
);
  logic [1:0][15:0] left;
  logic [1:0][7:0] timer;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      left <= '0;
      timer <= '0;
      pulse <= '0;
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (start[i])
        begin
          left[i] <= n_pulses[i];
          timer[i] <= 8'h00;
        end
        else if (left[i] != 16'h0000)
        begin
          if (timer[i] == 8'(HALF_CYC - 1))
          begin
            timer[i] <= 8'h00;
            pulse[i] <= ~pulse[i];
            // Falling edge ends one pulse
            if (pulse[i])
            begin
              left[i] <= left[i] - 16'h0001;
            end
          end
          else
          begin
            timer[i] <= timer[i] + 8'h01;
          end
        end
      end
    end
  end

  // Busy while pulses remain
  assign busy[0] = (left[0] != 16'h0000);
  assign busy[1] = (left[1] != 16'h0000);
endmodule

// ### verification/dpc_top_tb.sv
`timescale 1ns/100ps
// ==================================================================
// Self-checking bench for the pulse counter block
module dpc_top_tb;
  localparam logic [11:0] A_RTC = {2'b00, dpc_pkg::RTC_CONTROL_IDX, 2'b00};
  localparam logic [11:0] A_CTL = {2'b00, dpc_pkg::PULSE_COUNTER_CONTROL_IDX, 2'b00};
  localparam logic [11:0] A_1L = {2'b00, dpc_pkg::COUNT_ONE_LOW_IDX, 2'b00};
  localparam logic [11:0] A_1H = {2'b00, dpc_pkg::COUNT_ONE_HIGH_IDX, 2'b00};
  localparam logic [11:0] A_2L = {2'b00, dpc_pkg::COUNT_TWO_LOW_IDX, 2'b00};
  localparam logic [11:0] A_2H = {2'b00, dpc_pkg::COUNT_TWO_HIGH_IDX, 2'b00};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic external_irq_pin_n, rtc_overflow, irq_in_service, ext_irq_req, deriv_irq_grant;
  logic [1:0] start, pulse, busy;
  logic [1:0][15:0] n_pulses;
  int num_errors, checks;

  dpc_top dpc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pulse_input_one(pulse[0]), .pulse_input_two(pulse[1]),
    .external_irq_pin_n(external_irq_pin_n), .rtc_overflow(rtc_overflow),
    .irq_in_service(irq_in_service), .ext_irq_req(ext_irq_req),
    .deriv_irq_grant(deriv_irq_grant));
  dpc_pulse_src dpc_pulse_src_i (.pclk(pclk), .presetn(presetn), .start(start),
    .n_pulses(n_pulses), .pulse(pulse), .busy(busy));

  // Clock of 5 ns
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer, held until pready
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 20)
    begin
      k++;
      @(posedge pclk);
    end
    if (k == 20)
    begin
      num_errors++;
    end
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Read and compare
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0000_0000);
    check(rd, exp);
  endtask

  // Pulse each pin given a nonzero count, optionally reading meanwhile
  task automatic send(input logic [15:0] n1, input logic [15:0] n2, input logic rdx);
    int k;
    k = 0;
    @(posedge pclk);
    start <= {n2 != 16'h0000, n1 != 16'h0000};
    n_pulses <= {n2, n1};
    @(posedge pclk);
    start <= 2'b00;
    @(posedge pclk);
    while (busy !== 2'b00 && k < 60000)
    begin
      k++;
      if (rdx)
      begin
        apb(A_1L, 1'b0, 32'h0000_0000);
      end
      else
      begin
        @(posedge pclk);
      end
    end
    repeat (8) @(posedge pclk);
  endtask

  // Interrupt outputs after they settle
  task automatic irq_chk(input logic req, input logic grant);
    repeat (8) @(posedge pclk);
    check({30'h0, ext_irq_req, deriv_irq_grant}, {30'h0, req, grant});
  endtask

  // Verdict and end of run
  task automatic tally_and_finish;
    if (num_errors == 0 && checks > 0)
    begin
      $display("Testbench passed");
    end
    else
    begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Watchdog against a hang
  initial
  begin
    #400000;
    num_errors++;
    tally_and_finish();
  end

  // ================================================================
  // Test sequence
  initial
  begin
    {presetn, psel, penable, pwrite, rtc_overflow, irq_in_service} = 6'h00;
    {paddr, pwdata, start, n_pulses} = '0;
    external_irq_pin_n = 1'b1;
    num_errors = 0;
    checks = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(A_RTC, 32'h0000_0000);
    for (int i = 0; i < 5; i++) rd_chk(A_CTL + 12'(4 * i), 32'h0000_0000);
    check({31'h0, rerr}, 32'h0000_0000);
    rd_chk(12'h114, 32'h0000_0000);
    check({31'h0, rerr}, 32'h0000_0001);
    rd_chk(12'h102, 32'h0000_0000);
    check({31'h0, rerr}, 32'h0000_0001);
    apb(A_CTL, 1'b1, 32'h0000_00FF);
    rd_chk(A_CTL, 32'h0000_00DD);
    irq_chk(1'b1, 1'b1);
    irq_in_service <= 1'b1;
    irq_chk(1'b1, 1'b0);
    irq_in_service <= 1'b0;
    external_irq_pin_n <= 1'b0;
    irq_chk(1'b1, 1'b0);
    external_irq_pin_n <= 1'b1;
    apb(A_CTL, 1'b1, 32'h0000_0011);
    irq_chk(1'b0, 1'b0);
    apb(A_CTL, 1'b1, 32'h0000_0088);
    send(16'h0005, 16'h0003, 1'b1);
    apb(A_CTL, 1'b1, 32'h0000_0000);
    rd_chk(A_1L, 32'h0000_0005);
    rd_chk(A_1H, 32'h0000_0000);
    rd_chk(A_2L, 32'h0000_0003);
    send(16'h0002, 16'h0002, 1'b0);
    apb(A_CTL, 1'b1, 32'h0000_0080);
    send(16'h0001, 16'h0001, 1'b0);
    apb(A_CTL, 1'b1, 32'h0000_0000);
    rd_chk(A_1L, 32'h0000_0006);
    rd_chk(A_2L, 32'h0000_0003);
    apb(A_1L, 1'b1, 32'h0000_00FE);
    apb(A_1H, 1'b1, 32'h0000_00FF);
    rd_chk(A_1H, 32'h0000_00FF);
    apb(A_CTL, 1'b1, 32'h0000_00C0);
    send(16'h0002, 16'h0000, 1'b0);
    rd_chk(A_CTL, 32'h0000_00D0);
    irq_chk(1'b1, 1'b1);
    apb(A_CTL, 1'b1, 32'h0000_0040);
    rd_chk(A_1L, 32'h0000_0000);
    irq_chk(1'b0, 1'b0);
    apb(A_1L, 1'b1, 32'h0000_00FF);
    apb(A_1H, 1'b1, 32'h0000_00FF);
    apb(A_CTL, 1'b1, 32'h0000_00C0);
    send(16'h0001, 16'h0000, 1'b0);
    rd_chk(A_CTL, 32'h0000_00C0);
    for (int k = 0; k < 2; k++)
    begin
      apb(A_2L, 1'b1, 32'h0000_00FE);
      apb(A_2H, 1'b1, 32'h0000_00FF);
      apb(A_CTL, 1'b1, 32'h0000_0008 | 32'(4 * k));
      send(16'h0000, 16'h0002, 1'b0);
      rd_chk(A_CTL, 32'h0000_0008 | 32'(5 * k));
    end
    apb(A_CTL, 1'b1, 32'h0000_0000);
    @(posedge pclk);
    rtc_overflow <= 1'b1;
    @(posedge pclk);
    rtc_overflow <= 1'b0;
    rd_chk(A_RTC, 32'h0000_0002);
    irq_chk(1'b0, 1'b0);
    apb(A_RTC, 1'b1, 32'h0000_0003);
    irq_chk(1'b1, 1'b1);
    apb(A_RTC, 1'b1, 32'h0000_0000);
    irq_chk(1'b0, 1'b0);
    external_irq_pin_n <= 1'b0;
    irq_chk(1'b1, 1'b0);
    rd_chk(A_CTL, 32'h0000_0000);
    rd_chk(A_RTC, 32'h0000_0000);
    tally_and_finish();
  end
endmodule
